// *** design/uoc_regs.svh ***
`ifndef UOC_REGS_SVH
`define UOC_REGS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define UOC_OFF_IRQ_EN 8'h00
`define UOC_OFF_CTRL 8'h04
`define UOC_OFF_SOF 8'h08
`define UOC_OFF_EVENTS 8'h0C
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UOC_IE_ID 7
`define UOC_IE_MS 6
`define UOC_IE_LINE 5
`define UOC_IE_ACT 4
`define UOC_IE_SESV 3
`define UOC_IE_SESEND 2
`define UOC_IE_VBUS 0
`define UOC_IE_MASK 8'hFD
`define UOC_CT_J 7
`define UOC_CT_SE0 6
`define UOC_CT_HOLD 5
`define UOC_CT_BRST 4
`define UOC_CT_HOST 3
`define UOC_CT_RESUME 2
`define UOC_CT_PPRST 1
`define UOC_CT_EN 0
`define UOC_CT_WMASK 8'h3F
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define UOC_RST_BYTE 8'h00
`define UOC_CLK_MHZ 250
`define UOC_LS_EOP_NS 1333
`define UOC_LS_EOP_CYC ((`UOC_LS_EOP_NS * `UOC_CLK_MHZ) / 1000)
`endif

// *** design/uoc_pkg.sv ***
`default_nettype none
package uoc_pkg;
  typedef enum logic [2:0] {
    UOC_IDLE = 3'b001,
    UOC_RESUME = 3'b010,
    UOC_EOP = 3'b100
  } uoc_sig_t;
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } uoc_axi_st_t;
endpackage : uoc_pkg
`default_nettype wire

// *** design/uoc_bus_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface uoc_bus_if;
  logic wr;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [7:0] raddr;
  logic [31:0] rdata;
  logic rmapped;
  logic wmapped;
  modport slave (output wr, output waddr, output wdata, output wstrb, output raddr,
    input rdata, input rmapped, input wmapped);
  modport core (input wr, input waddr, input wdata, input wstrb, input raddr,
    output rdata, output rmapped, output wmapped);
endinterface : uoc_bus_if
`default_nettype wire

// *** design/uoc_axil.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uoc_regs.svh"
module uoc_axil
  import uoc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // core side
  uoc_bus_if.slave bus
);
  uoc_axi_st_t st, next_st;
  logic do_wr;

  assign awready = !st.aw_got && !st.bvalid;
  assign wready = !st.w_got && !st.bvalid;
  assign arready = !st.rvalid;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign do_wr = st.aw_got && st.w_got && !st.bvalid;
  assign bus.wr = do_wr && bus.wmapped;
  assign bus.waddr = st.aw_addr;
  assign bus.wdata = st.wdata;
  assign bus.wstrb = st.wstrb;
  assign bus.raddr = araddr;

  always_comb
  begin
    next_st = st;
    if (awvalid && awready)
    begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end
    if (do_wr)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      // unmapped address answers slave error
      next_st.bresp = bus.wmapped ? 2'h0 : 2'h2;
    end
    if (st.bvalid && bready)
      next_st.bvalid = 1'b0;
    if (st.rvalid && rready)
      next_st.rvalid = 1'b0;
    if (arvalid && arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = bus.rmapped ? bus.rdata : 32'h0;
      next_st.rresp = bus.rmapped ? 2'h0 : 2'h2;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end
endmodule : uoc_axil
`default_nettype wire

// *** design/uoc_usb_ctrl.sv ***
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "uoc_regs.svh"
// Functional notes
// - bits 31..8 read zero, writes ignored
// - id change irq gated by enable bit 7
// - millisecond timer irq gated by bit 6
// - line state irq gated by bit 5
// - bus activity irq gated by bit 4
// - session valid irq gated by bit 3
// - session end irq bit 2; bit 1 zero
// - vbus valid irq gated by bit 0
// - control bit 7 live J state
// - control bit 6 live single-ended zero
// - device: bit 5 holds processing, setup sets
// - host: bit 5 shows token in progress
// - host: bit 4 drives bus reset
// - bit 3 host enable; toggle resets host
// - host: resume release appends low-speed EOP
module uoc_usb_ctrl
  import uoc_pkg::*;
#(
  parameter int EOP_CYCLES = `UOC_LS_EOP_CYC
)
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // axi4-lite write
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // axi4-lite read
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // line status from the transceiver
  input wire logic LINE_J,
  input wire logic LINE_SE0,
  // otg event pulses
  input wire logic EV_ID_CHANGE,
  input wire logic EV_MSEC_TICK,
  input wire logic EV_LINE_STATE,
  input wire logic EV_BUS_ACTIVITY,
  input wire logic EV_SESSION_VALID,
  input wire logic EV_SESSION_END,
  input wire logic EV_VBUS_VALID,
  // gated event pulses
  output logic IRQ_ID_CHANGE,
  output logic IRQ_MSEC_TICK,
  output logic IRQ_LINE_STATE,
  output logic IRQ_BUS_ACTIVITY,
  output logic IRQ_SESSION_VALID,
  output logic IRQ_SESSION_END,
  output logic IRQ_VBUS_VALID,
  // protocol engine
  input wire logic SETUP_RECEIVED,
  input wire logic TOKEN_ACTIVE,
  input wire logic [7:0] BYTES_TO_SOF,
  input wire logic TXN_REQUEST,
  output logic TXN_START,
  output logic PACKET_HOLD,
  output logic HOST_LOGIC_RESET,
  output logic MODULE_ENABLE,
  output logic PINGPONG_RESET,
  // bus signalling
  output logic DRIVE_BUS_RESET,
  output logic DRIVE_RESUME,
  output logic DRIVE_LS_EOP
);
  typedef struct packed {
    logic [7:0] irq_en;
    logic hold;
    logic bus_reset_drive;
    logic host_capability_enable;
    logic resume;
    logic pingpong_pointer_reset;
    logic module_enable;
    logic [7:0] sof_threshold_count;
    logic [6:0] ev_seen;
    logic host_rst;
    uoc_sig_t sig;
    logic [15:0] eop_cnt;
  } uoc_ctl_st_t;

  uoc_ctl_st_t st, next_st;
  uoc_bus_if bus ();
  logic [7:0] ctrl_byte;
  logic [6:0] ev_raw;
  logic [6:0] ev_gated;

  uoc_axil u_axil (
    .clk(CLOCK),
    .rst(RST),
    .awvalid(AWVALID),
    .awready(AWREADY),
    .awaddr(AWADDR),
    .wvalid(WVALID),
    .wready(WREADY),
    .wdata(WDATA),
    .wstrb(WSTRB),
    .bvalid(BVALID),
    .bready(BREADY),
    .bresp(BRESP),
    .arvalid(ARVALID),
    .arready(ARREADY),
    .araddr(ARADDR),
    .rvalid(RVALID),
    .rready(RREADY),
    .rdata(RDATA),
    .rresp(RRESP),
    .bus(bus.slave)
  );

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `UOC_OFF_IRQ_EN) || (a == `UOC_OFF_CTRL) ||
      (a == `UOC_OFF_SOF) || (a == `UOC_OFF_EVENTS);
  endfunction : mapped

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_byte = 8'h00;
    ctrl_byte[`UOC_CT_J] = LINE_J;
    ctrl_byte[`UOC_CT_SE0] = LINE_SE0;
    // bit 5 shares two meanings by mode
    ctrl_byte[`UOC_CT_HOLD] = st.host_capability_enable ? TOKEN_ACTIVE : st.hold;
    ctrl_byte[`UOC_CT_BRST] = st.bus_reset_drive;
    ctrl_byte[`UOC_CT_HOST] = st.host_capability_enable;
    ctrl_byte[`UOC_CT_RESUME] = st.resume;
    ctrl_byte[`UOC_CT_PPRST] = st.pingpong_pointer_reset;
    ctrl_byte[`UOC_CT_EN] = st.module_enable;
  end

  assign bus.wmapped = mapped(bus.waddr);
  assign bus.rmapped = mapped(bus.raddr);
  always_comb
  begin
    bus.rdata = 32'h0;
    case (bus.raddr)
      `UOC_OFF_IRQ_EN: bus.rdata[7:0] = st.irq_en;
      `UOC_OFF_CTRL: bus.rdata[7:0] = ctrl_byte;
      `UOC_OFF_SOF: bus.rdata[7:0] = st.sof_threshold_count;
      `UOC_OFF_EVENTS: bus.rdata[7:0] = {1'b0, st.ev_seen};
      default: bus.rdata = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // event gating
  // ----------------------------------------------------------------
  assign ev_raw = {EV_ID_CHANGE, EV_MSEC_TICK, EV_LINE_STATE, EV_BUS_ACTIVITY,
    EV_SESSION_VALID, EV_SESSION_END, EV_VBUS_VALID};
  assign ev_gated = ev_raw & {st.irq_en[7:2], st.irq_en[0]};
  assign IRQ_ID_CHANGE = ev_gated[6];
  assign IRQ_MSEC_TICK = ev_gated[5];
  assign IRQ_LINE_STATE = ev_gated[4];
  assign IRQ_BUS_ACTIVITY = ev_gated[3];
  assign IRQ_SESSION_VALID = ev_gated[2];
  assign IRQ_SESSION_END = ev_gated[1];
  assign IRQ_VBUS_VALID = ev_gated[0];

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PACKET_HOLD = !st.host_capability_enable && st.hold;
  assign HOST_LOGIC_RESET = st.host_rst;
  assign MODULE_ENABLE = st.module_enable;
  assign PINGPONG_RESET = st.pingpong_pointer_reset;
  assign DRIVE_BUS_RESET = st.host_capability_enable && st.bus_reset_drive;
  assign DRIVE_RESUME = st.sig == UOC_RESUME;
  assign DRIVE_LS_EOP = st.sig == UOC_EOP;
  // software must also wait for idle; hardware gates here too
  assign TXN_START = st.host_capability_enable && TXN_REQUEST && !TOKEN_ACTIVE &&
    !st.host_rst && (BYTES_TO_SOF >= st.sof_threshold_count);

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.host_rst = 1'b0;
    next_st.ev_seen = st.ev_seen | ev_raw;
    if (bus.wr && bus.wstrb[0])
    begin
      case (bus.waddr)
        `UOC_OFF_IRQ_EN: next_st.irq_en = bus.wdata[7:0] & `UOC_IE_MASK;
        `UOC_OFF_CTRL:
        begin
          next_st.hold = bus.wdata[`UOC_CT_HOLD];
          next_st.bus_reset_drive = bus.wdata[`UOC_CT_BRST];
          next_st.host_capability_enable = bus.wdata[`UOC_CT_HOST];
          next_st.resume = bus.wdata[`UOC_CT_RESUME];
          next_st.pingpong_pointer_reset = bus.wdata[`UOC_CT_PPRST];
          next_st.module_enable = bus.wdata[`UOC_CT_EN];
          // any change of host enable pulses host reset
          if (bus.wdata[`UOC_CT_HOST] != st.host_capability_enable)
            next_st.host_rst = 1'b1;
        end
        `UOC_OFF_SOF: next_st.sof_threshold_count = bus.wdata[7:0];
        // write-one-to-clear; new events below still win
        `UOC_OFF_EVENTS: next_st.ev_seen = (st.ev_seen & ~bus.wdata[6:0]) | ev_raw;
        default: next_st.ev_seen = st.ev_seen | ev_raw;
      endcase
    end
    // setup arrival wins over a software clear
    if (SETUP_RECEIVED && !st.host_capability_enable)
      next_st.hold = 1'b1;
    case (st.sig)
      UOC_IDLE:
        if (next_st.resume)
          next_st.sig = UOC_RESUME;
      UOC_RESUME:
        if (!next_st.resume)
        begin
          next_st.sig = st.host_capability_enable ? UOC_EOP : UOC_IDLE;
          next_st.eop_cnt = 16'(EOP_CYCLES - 1);
        end
      UOC_EOP:
        if (st.eop_cnt == 16'h0)
          next_st.sig = UOC_IDLE;
        else
          next_st.eop_cnt = st.eop_cnt - 16'h1;
      default: next_st.sig = UOC_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      st <= '0;
      st.sig <= UOC_IDLE;
    end
    else
      st <= next_st;
  end
endmodule : uoc_usb_ctrl
`default_nettype wire

// *** bench/uoc_usb_ctrl_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uoc_regs.svh"
module uoc_usb_ctrl_sva
  import uoc_pkg::*;
#(
  parameter int EOP_CYCLES = `UOC_LS_EOP_CYC
)
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // bus answers
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic RVALID,
  input wire logic [31:0] RDATA,
  // events in
  input wire logic EV_ID_CHANGE,
  input wire logic EV_MSEC_TICK,
  input wire logic EV_LINE_STATE,
  input wire logic EV_BUS_ACTIVITY,
  input wire logic EV_SESSION_VALID,
  input wire logic EV_SESSION_END,
  input wire logic EV_VBUS_VALID,
  // gated events
  input wire logic IRQ_ID_CHANGE,
  input wire logic IRQ_MSEC_TICK,
  input wire logic IRQ_LINE_STATE,
  input wire logic IRQ_BUS_ACTIVITY,
  input wire logic IRQ_SESSION_VALID,
  input wire logic IRQ_SESSION_END,
  input wire logic IRQ_VBUS_VALID,
  // engine and signalling
  input wire logic TXN_START,
  input wire logic TXN_REQUEST,
  input wire logic TOKEN_ACTIVE,
  input wire logic HOST_LOGIC_RESET,
  input wire logic PACKET_HOLD,
  input wire logic DRIVE_BUS_RESET,
  input wire logic DRIVE_RESUME,
  input wire logic DRIVE_LS_EOP
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  // length counted here, a repetition cannot follow the parameter
  int eop_run;
  always_ff @(posedge CLOCK)
  begin
    if (RST || !DRIVE_LS_EOP)
      eop_run <= 0;
    else
      eop_run <= eop_run + 1;
  end
  upper_zero_a: assert property (RVALID |-> RDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  id_gate_a: assert property (IRQ_ID_CHANGE |-> EV_ID_CHANGE)
    else $error("id irq without event");
  msec_gate_a: assert property (IRQ_MSEC_TICK |-> EV_MSEC_TICK)
    else $error("timer irq without event");
  other_gate_a: assert property ((IRQ_LINE_STATE && !EV_LINE_STATE)
    || (IRQ_BUS_ACTIVITY && !EV_BUS_ACTIVITY) || (IRQ_SESSION_VALID && !EV_SESSION_VALID)
    || (IRQ_SESSION_END && !EV_SESSION_END) || (IRQ_VBUS_VALID && !EV_VBUS_VALID) |-> 1'b0)
    else $error("irq without event");
  txn_gate_a: assert property (TXN_START |-> TXN_REQUEST && !TOKEN_ACTIVE)
    else $error("transaction started while busy");
  host_pulse_a: assert property (HOST_LOGIC_RESET |=> !HOST_LOGIC_RESET)
    else $error("host reset longer than one cycle");
  eop_cause_a: assert property ($rose(DRIVE_LS_EOP) |-> $past(DRIVE_RESUME))
    else $error("eop without resume");
  eop_len_a: assert property ($fell(DRIVE_LS_EOP) |-> eop_run == EOP_CYCLES)
    else $error("eop length wrong");
  eop_max_a: assert property (DRIVE_LS_EOP |-> eop_run < EOP_CYCLES)
    else $error("eop longer than expected");
  mode_excl_a: assert property (PACKET_HOLD |-> !DRIVE_BUS_RESET)
    else $error("hold and bus reset together");
  bvalid_hold_a: assert property (BVALID && !BREADY |=> BVALID)
    else $error("write response dropped");
endmodule : uoc_usb_ctrl_sva
bind uoc_usb_ctrl uoc_usb_ctrl_sva #(.EOP_CYCLES(EOP_CYCLES)) chk_u (.*);
`default_nettype wire

// *** bench/uoc_line_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module uoc_line_model
(
  // signalling from the block
  input wire logic bus_reset,
  input wire logic resume,
  input wire logic ls_eop,
  // line levels back
  output logic line_j,
  output logic line_se0
);
  // reset and eop pull both lines low; resume drives k, so j drops
  assign line_se0 = bus_reset | ls_eop;
  assign line_j = !(bus_reset | ls_eop | resume);
endmodule : uoc_line_model
`default_nettype wire

// *** bench/uoc_usb_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uoc_regs.svh"
module uoc_usb_ctrl_tb;
  logic CLOCK = 0, RST = 1;
  logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic [7:0] AWADDR = 0, ARADDR = 0, BYTES_TO_SOF = 0;
  logic [31:0] WDATA = 0, rv;
  logic [3:0] WSTRB = 0;
  logic [1:0] rr, br;
  logic [3:0] strb = 4'hF;
  logic [6:0] ev = 0;
  logic SETUP_RECEIVED = 0, TOKEN_ACTIVE = 0, TXN_REQUEST = 0;
  wire logic EV_ID_CHANGE, EV_MSEC_TICK, EV_LINE_STATE, EV_BUS_ACTIVITY;
  wire logic EV_SESSION_VALID, EV_SESSION_END, EV_VBUS_VALID, LINE_J, LINE_SE0;
  wire logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TXN_START, PACKET_HOLD;
  wire logic [1:0] BRESP, RRESP;
  wire logic [31:0] RDATA;
  wire logic IRQ_ID_CHANGE, IRQ_MSEC_TICK, IRQ_LINE_STATE, IRQ_BUS_ACTIVITY;
  wire logic IRQ_SESSION_VALID, IRQ_SESSION_END, IRQ_VBUS_VALID, HOST_LOGIC_RESET;
  wire logic MODULE_ENABLE, PINGPONG_RESET, DRIVE_BUS_RESET, DRIVE_RESUME, DRIVE_LS_EOP;
  wire logic [6:0] irq = {IRQ_ID_CHANGE, IRQ_MSEC_TICK, IRQ_LINE_STATE, IRQ_BUS_ACTIVITY,
    IRQ_SESSION_VALID, IRQ_SESSION_END, IRQ_VBUS_VALID};
  int err_total = 0, checks_done = 0, eop_n = 0, hr_n = 0;
  assign {EV_ID_CHANGE, EV_MSEC_TICK, EV_LINE_STATE, EV_BUS_ACTIVITY, EV_SESSION_VALID,
    EV_SESSION_END, EV_VBUS_VALID} = ev;
  always #2 CLOCK = ~CLOCK;
  // pulse widths are counted here so a task returning late misses nothing
  always @(posedge CLOCK)
  begin
    eop_n += DRIVE_LS_EOP;
    hr_n += HOST_LOGIC_RESET;
  end
  uoc_usb_ctrl #(.EOP_CYCLES(4)) dut_u (.*);
  uoc_line_model far_u (.bus_reset(DRIVE_BUS_RESET), .resume(DRIVE_RESUME),
    .ls_eop(DRIVE_LS_EOP), .line_j(LINE_J), .line_se0(LINE_SE0));
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  // ready is looked at mid-cycle, then the edge takes the item
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b, ao, wo;
    aw = 1;
    w = 1;
    b = 0;
    @(posedge CLOCK);
    AWVALID <= 1;
    AWADDR <= a;
    WVALID <= 1;
    WDATA <= d;
    WSTRB <= strb;
    BREADY <= 1;
    while (aw || w || !b)
    begin
      @(negedge CLOCK);
      ao = AWREADY === 1'b1;
      wo = WREADY === 1'b1;
      b = !aw && !w && BVALID === 1'b1;
      if (b) br = BRESP;
      @(posedge CLOCK);
      if (aw && ao) AWVALID <= 0;
      if (w && wo) WVALID <= 0;
      aw = aw && !ao;
      w = w && !wo;
    end
    BREADY <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, ok, got;
    ar = 1;
    got = 0;
    @(posedge CLOCK);
    ARVALID <= 1;
    ARADDR <= a;
    RREADY <= 1;
    while (!got)
    begin
      @(negedge CLOCK);
      ok = ar ? ARREADY === 1'b1 : RVALID === 1'b1;
      d = RDATA;
      r = RRESP;
      @(posedge CLOCK);
      if (ar && ok) ARVALID <= 0;
      got = !ar && ok;
      ar = ar && !ok;
    end
    RREADY <= 0;
  endtask : rd
  task automatic chk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a, rv, rr);
    cmp(n, e, rv);
  endtask : chk
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    chk("irq_rst", `UOC_OFF_IRQ_EN, 32'h00000000);
    chk("ctrl_rst", `UOC_OFF_CTRL, 32'h00000080);
    chk("sof_rst", `UOC_OFF_SOF, 32'h00000000);
    rd(8'h40, rv, rr);
    cmp("resp_unmapped", 32'h2, {30'h0, rr});
    cmp("data_unmapped", 32'h0, rv);
    wr(8'h40, 32'hFFFFFFFF);
    cmp("bresp_unmapped", 32'h2, {30'h0, br});
  endtask : t_regs
  task automatic t_irq;
    logic [7:0] m;
    wr(`UOC_OFF_IRQ_EN, 32'hFFFFFFFF);
    cmp("bresp_ok", 32'h0, {30'h0, br});
    chk("irq_en", `UOC_OFF_IRQ_EN, 32'h000000FD);
    for (int i = 0; i < 8; i++)
    begin
      m = 8'h01 << i;
      wr(`UOC_OFF_IRQ_EN, {24'h0, m});
      @(posedge CLOCK);
      ev <= 7'h7F;
      @(negedge CLOCK);
      cmp("irq", {25'h0, m[7:2], m[0]}, {25'h0, irq});
      @(posedge CLOCK);
      ev <= 7'h00;
    end
    // every event was pulsed in each of the eight passes, so all seen flags stand
    chk("ev_seen", `UOC_OFF_EVENTS, 32'h0000007F);
    wr(`UOC_OFF_EVENTS, 32'h7F);
    chk("ev_clear", `UOC_OFF_EVENTS, 32'h00000000);
  endtask : t_irq
  task automatic t_dev;
    wr(`UOC_OFF_CTRL, 32'h01);
    @(posedge CLOCK);
    SETUP_RECEIVED <= 1;
    TXN_REQUEST <= 1;
    BYTES_TO_SOF <= 8'hFF;
    @(posedge CLOCK);
    SETUP_RECEIVED <= 0;
    chk("ctrl_dev", `UOC_OFF_CTRL, 32'hA1);
    @(negedge CLOCK);
    cmp("hold", 1, PACKET_HOLD);
    cmp("txn_dev", 0, TXN_START);
    wr(`UOC_OFF_CTRL, 32'h01);
    chk("ctrl_clr", `UOC_OFF_CTRL, 32'h81);
    wr(`UOC_OFF_CTRL, 32'h03);
    @(negedge CLOCK);
    cmp("enable", 1, MODULE_ENABLE);
    cmp("pingpong", 1, PINGPONG_RESET);
  endtask : t_dev
  task automatic t_host;
    wr(`UOC_OFF_CTRL, 32'h08);
    wr(`UOC_OFF_SOF, 32'h1234564A);
    chk("sof", `UOC_OFF_SOF, 32'h4A);
    // byte lane 0 off: the write must leave the threshold alone
    strb = 4'hE;
    wr(`UOC_OFF_SOF, 32'h11);
    strb = 4'hF;
    chk("sof_strb", `UOC_OFF_SOF, 32'h4A);
    TOKEN_ACTIVE <= 1;
    BYTES_TO_SOF <= 8'h4A;
    chk("ctrl_tok", `UOC_OFF_CTRL, 32'hA8);
    @(negedge CLOCK);
    cmp("txn_tok", 0, TXN_START);
    cmp("hrst", 1, hr_n);
    cmp("enable_off", 0, MODULE_ENABLE);
    cmp("pingpong_off", 0, PINGPONG_RESET);
    @(posedge CLOCK);
    TOKEN_ACTIVE <= 0;
    @(negedge CLOCK);
    cmp("txn_eq", 1, TXN_START);
    @(posedge CLOCK);
    BYTES_TO_SOF <= 8'h49;
    @(negedge CLOCK);
    cmp("txn_low", 0, TXN_START);
    wr(`UOC_OFF_CTRL, 32'h18);
    chk("ctrl_brst", `UOC_OFF_CTRL, 32'h58);
    wr(`UOC_OFF_CTRL, 32'h0C);
    chk("ctrl_res", `UOC_OFF_CTRL, 32'h0C);
    eop_n = 0;
    wr(`UOC_OFF_CTRL, 32'h08);
    repeat (10) @(posedge CLOCK);
    cmp("eop", 4, eop_n);
    wr(`UOC_OFF_CTRL, 32'h00);
    @(posedge CLOCK);
    cmp("hrst2", 2, hr_n);
  endtask : t_host
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (2) @(posedge CLOCK);
    RST <= 0;
    t_regs;
    t_irq;
    t_dev;
    t_host;
    summarize;
  end
  initial
  begin
    repeat (20000) @(posedge CLOCK);
    err_total++;
    summarize;
  end
endmodule : uoc_usb_ctrl_tb
`default_nettype wire
